// file: logic/mlh_regs.svh
// Register offsets, field positions, reset values and timing counts of the manual loader.
// Assumes a 125 MHz system clock and a byte-addressed register port with one word per register.
`ifndef MLH_REGS_SVH
`define MLH_REGS_SVH
`define MLH_OFF_CTRL 8'h00
`define MLH_OFF_TIMEOUT 8'h04
`define MLH_OFF_STATUS 8'h08
`define MLH_OFF_IRQ_STAT 8'h0C
`define MLH_OFF_IRQ_MASK 8'h10
`define MLH_CTRL_CREEP 0
`define MLH_STAT_FAULT_LO 4
`define MLH_STAT_CODE_LO 8
`define MLH_STAT_VALID 14
`define MLH_IRQ_NOGOODS 0
`define MLH_IRQ_TRANSFER 1
`define MLH_IRQ_STUCK 2
`define MLH_IRQ_DONE 3
`define MLH_TIMEOUT_RST 16'h2710
`define MLH_CLK_MHZ 125
`define MLH_TICK_US 1000
`define MLH_TICK_CYC (`MLH_TICK_US * `MLH_CLK_MHZ)
`define MLH_DONE_MS 2000
`define MLH_CHECK_MS 5000
`define MLH_JOG_MS 500
`endif

// file: logic/mlh_pkg.sv
// Types shared by the manual loader design files.
// Assumes nothing of its surroundings.
package mlh_pkg;
   typedef enum logic [1:0] {
      FLT_NONE,
      FLT_TRANSFER,
      FLT_STUCK,
      FLT_NOGOODS
   } mlh_fault_e;
   typedef enum logic [3:0] {
      ST_LOAD,
      ST_RUN_EYE,
      ST_WAIT_PERMIT,
      ST_WAIT_PREP,
      ST_WAIT_START,
      ST_DISCH,
      ST_DONE,
      ST_CHECK,
      ST_FAULT,
      ST_REARM
   } mlh_state_e;
endpackage : mlh_pkg

// file: logic/mlh_tick_div.sv
// Divider that turns the system clock into a one-cycle tick enable.
// Assumes a synchronous active-low reset already released cleanly.
`timescale 1ns/10ps
module mlh_tick_div
#(
   parameter int DIV = 125000
)
(
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt_q;

   // Free-running count; the tick fires once per wrap.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= (cnt_q == W'(DIV - 1));
         cnt_q <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule : mlh_tick_div

// file: logic/mlh_interval.sv
// Tick-based interval timer with restart and a sticky expired level.
// Assumes the tick is a one-cycle enable from the shared divider.
`timescale 1ns/10ps
module mlh_interval
#(
   parameter int W = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic restart,
   input wire logic [W-1:0] limit,
   output logic expired
);
   logic [W-1:0] cnt_q;

   // Restart wins over a tick so a new state always sees the full interval.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (restart)
         cnt_q <= '0;
      else if (tick && cnt_q < limit)
         cnt_q <= cnt_q + 1'b1;
   end

   assign expired = !restart && (cnt_q >= limit);
endmodule : mlh_interval

// file: logic/mlh_loader.sv
// Sequencer of a hand-loaded, forward-only belt with one discharge photoeye.
// Assumes synchronous operator and line-controller inputs and a plain register port.
// What this block does
// - Accept a six-bit binary wash code, codes 00 to 63, from the operator.
// - Pass the latched wash code on toward the line controller and washer.
// - Take a code-valid input and a belt-loaded input from the operator.
// - Run the belt forward only; one photoeye sits at the discharge end.
// - Raise the load request output when a loading cycle starts.
// - Keep the belt stopped while loading, except optional creep jogging.
// - Loaded input after the latch drops the load request output.
// - Run until the eye blocks; timeout raises goods-missing fault 03.
// - Hold any fault until the fault-acknowledge key, then clear it.
// - While unload permit is grounded, request unload and wait for a reply.
// - On prepare, drop the receiver stop flag, report ready, and wait.
// - On the start command, run the belt motor to discharge.
// - An interrupted discharge raises transfer fault 01.
// - Stop when timeout expired and eye clear; pulse unload-complete two seconds.
// - Five seconds later require loaded and latch inactive, else fault 02.
// - Once those switches reset, raise load request and start again.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "mlh_regs.svh"
module mlh_loader
#(
   parameter int TICK_CYC = `MLH_TICK_CYC
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic [5:0] washCodeIn,
   input wire logic codeLatch,
   input wire logic beltLoaded,
   input wire logic photoeyeBlocked,
   input wire logic unloadPermit_n,
   input wire logic prepareCmd,
   input wire logic startCmd,
   input wire logic abortCmd,
   input wire logic faultAck,
   output logic loadRequest,
   output logic motorForward,
   output logic wantUnload,
   output logic readyDischarge,
   output logic holdReceiver,
   output logic unloadDone,
   output logic [5:0] washCodeOut,
   output logic washCodeValid,
   output mlh_pkg::mlh_fault_e faultCode,
   output logic irq
);
   import mlh_pkg::*;

   logic rstMeta_q;
   logic rst_n;
   mlh_state_e state_q;
   mlh_state_e state_d;
   logic entry_q;
   logic tick;
   logic creepEn_q;
   logic [15:0] timeout_q;
   logic [3:0] irqStat_q;
   logic [3:0] irqMask_q;
   logic [3:0] irqSet;
   logic [5:0] code_q;
   logic codeValid_q;
   logic latchPrev_q;
   logic jog_q;
   logic jogRestart_q;
   logic beltExp;
   logic doneExp;
   logic checkExp;
   logic jogExp;
   logic eventDone;
   mlh_fault_e fault_q;
   mlh_fault_e faultNew;
   mlh_fault_e faultNext;

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rst_n <= rstMeta_q;
      end
   end

   // One shared tick keeps all intervals on the same time base.
   mlh_tick_div #(.DIV(TICK_CYC)) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Belt-clear timeout, used both before and during discharge.
   mlh_interval #(.W(16)) u_belt (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(entry_q),
      .limit(timeout_q),
      .expired(beltExp)
   );

   mlh_interval #(.W(16)) u_done (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(entry_q),
      .limit(16'(`MLH_DONE_MS)),
      .expired(doneExp)
   );

   mlh_interval #(.W(16)) u_check (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(entry_q),
      .limit(16'(`MLH_CHECK_MS)),
      .expired(checkExp)
   );

   // Jog timer restarts on each half period of the creep pattern.
   mlh_interval #(.W(16)) u_jog (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(entry_q || jogRestart_q),
      .limit(16'(`MLH_JOG_MS)),
      .expired(jogExp)
   );

   // Next state and the fault raised by this transition, if any.
   always_comb
   begin
      state_d = state_q;
      faultNew = FLT_NONE;
      case (state_q)
         ST_LOAD:
            if (codeValid_q && beltLoaded)
               state_d = ST_RUN_EYE;
         ST_RUN_EYE:
            if (photoeyeBlocked)
               state_d = ST_WAIT_PERMIT;
            else if (beltExp)
            begin
               state_d = ST_FAULT;
               faultNew = FLT_NOGOODS;
            end
         ST_WAIT_PERMIT:
            if (!unloadPermit_n)
               state_d = ST_WAIT_PREP;
         ST_WAIT_PREP:
            if (prepareCmd)
               state_d = ST_WAIT_START;
            else if (unloadPermit_n)
               state_d = ST_WAIT_PERMIT;
         ST_WAIT_START:
            if (abortCmd)
            begin
               state_d = ST_FAULT;
               faultNew = FLT_TRANSFER;
            end
            else if (startCmd)
               state_d = ST_DISCH;
         ST_DISCH:
            if (abortCmd)
            begin
               state_d = ST_FAULT;
               faultNew = FLT_TRANSFER;
            end
            else if (beltExp && !photoeyeBlocked)
               state_d = ST_DONE;
         ST_DONE:
            if (doneExp)
               state_d = ST_CHECK;
         ST_CHECK:
            if (checkExp)
            begin
               if (beltLoaded || codeLatch)
               begin
                  state_d = ST_FAULT;
                  faultNew = FLT_STUCK;
               end
               else
                  state_d = ST_LOAD;
            end
         ST_FAULT:
            if (faultAck)
               state_d = ST_REARM;
         ST_REARM:
            if (!beltLoaded && !codeLatch)
               state_d = ST_LOAD;
         default:
            state_d = ST_LOAD;
      endcase
   end

   // State register; entry pulses restart every interval timer.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_LOAD;
         entry_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         entry_q <= (state_d != state_q);
      end
   end

   // Fault code is held until the acknowledge key; the pin copy takes the same next value so it never lags.
   assign faultNext = (faultNew != FLT_NONE) ? faultNew :
      (state_q == ST_FAULT && faultAck) ? FLT_NONE : fault_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_q <= FLT_NONE;
      else
         fault_q <= faultNext;
   end

   // Code capture on the rising edge of code-latch, only while loading.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_q <= 6'h00;
         codeValid_q <= 1'b0;
         latchPrev_q <= 1'b0;
      end
      else
      begin
         latchPrev_q <= codeLatch;
         if (state_q == ST_LOAD && codeLatch && !latchPrev_q)
         begin
            code_q <= washCodeIn;
            codeValid_q <= 1'b1;
         end
         else if (state_d == ST_LOAD && state_q != ST_LOAD)
            codeValid_q <= 1'b0;
      end
   end

   // Creep jog toggles each half period; it only matters while loading.
   // The jog timer restarts from a flop, since feeding its own expiry back would form a loop.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         jog_q <= 1'b0;
         jogRestart_q <= 1'b0;
      end
      else
      begin
         jogRestart_q <= jogExp;
         if (state_q != ST_LOAD)
            jog_q <= 1'b0;
         else if (jogExp)
            jog_q <= !jog_q;
      end
   end

   // Pin outputs come from flops and follow the next state, so they align with it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loadRequest <= 1'b0;
         motorForward <= 1'b0;
         wantUnload <= 1'b0;
         readyDischarge <= 1'b0;
         holdReceiver <= 1'b1;
         unloadDone <= 1'b0;
      end
      else
      begin
         loadRequest <= (state_d == ST_LOAD);
         motorForward <= (state_d == ST_RUN_EYE) || (state_d == ST_DISCH) ||
            (state_d == ST_LOAD && creepEn_q && jog_q);
         wantUnload <= (state_d == ST_WAIT_PREP);
         readyDischarge <= (state_d == ST_WAIT_START) || (state_d == ST_DISCH);
         holdReceiver <= !((state_d == ST_WAIT_START) || (state_d == ST_DISCH));
         unloadDone <= (state_d == ST_DONE);
      end
   end

   // Latched code travels on toward the line controller with its valid flag.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         washCodeOut <= 6'h00;
         washCodeValid <= 1'b0;
         faultCode <= FLT_NONE;
      end
      else
      begin
         washCodeOut <= code_q;
         washCodeValid <= codeValid_q;
         faultCode <= faultNext;
      end
   end

   // Control registers written by software.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         creepEn_q <= 1'b0;
         timeout_q <= `MLH_TIMEOUT_RST;
         irqMask_q <= 4'h0;
      end
      else if (regWrite)
      begin
         case (regAddr)
            `MLH_OFF_CTRL:
               creepEn_q <= regWrData[`MLH_CTRL_CREEP];
            `MLH_OFF_TIMEOUT:
               timeout_q <= regWrData[15:0];
            `MLH_OFF_IRQ_MASK:
               irqMask_q <= regWrData[3:0];
            default:
               creepEn_q <= creepEn_q;
         endcase
      end
   end

   assign eventDone = (state_q == ST_DONE) && entry_q;
   assign irqSet = {eventDone, faultNew == FLT_STUCK,
      faultNew == FLT_TRANSFER, faultNew == FLT_NOGOODS};

   // Sticky events; a new event in the clearing cycle survives the clear.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqStat_q <= 4'h0;
      else if (regWrite && regAddr == `MLH_OFF_IRQ_STAT)
         irqStat_q <= (irqStat_q & ~regWrData[3:0]) | irqSet;
      else
         irqStat_q <= irqStat_q | irqSet;
   end

   // Interrupt level follows any unmasked pending bit.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(irqStat_q & irqMask_q);
   end

   // Read data stand in the cycle after the strobe only; unmapped reads give zero.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 32'h0000_0000;
      else if (!regRead)
         regRdData <= 32'h0000_0000;
      else
      begin
         case (regAddr)
            `MLH_OFF_CTRL:
               regRdData <= {31'h0, creepEn_q};
            `MLH_OFF_TIMEOUT:
               regRdData <= {16'h0, timeout_q};
            `MLH_OFF_STATUS:
               regRdData <= {17'h0, codeValid_q, code_q, 2'h0, fault_q, state_q};
            `MLH_OFF_IRQ_STAT:
               regRdData <= {28'h0, irqStat_q};
            `MLH_OFF_IRQ_MASK:
               regRdData <= {28'h0, irqMask_q};
            default:
               regRdData <= 32'h0000_0000;
         endcase
      end
   end
endmodule : mlh_loader

// file: verif/mlh_loader_sva.sv
// Checker of the loader sequencing, watching the top-level ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module mlh_loader_sva
#(
   parameter int TICK_CYC = 4
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic codeLatch,
   input wire logic beltLoaded,
   input wire logic unloadPermit_n,
   input wire logic startCmd,
   input wire logic abortCmd,
   input wire logic faultAck,
   input wire logic loadRequest,
   input wire logic motorForward,
   input wire logic wantUnload,
   input wire logic readyDischarge,
   input wire logic holdReceiver,
   input wire logic unloadDone,
   input wire mlh_pkg::mlh_fault_e faultCode
);
   import mlh_pkg::*;
   logic [31:0] doneCnt_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Pulse length counter, since a tick too many is invisible on a waveform.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         doneCnt_q <= 32'h0;
      else
         doneCnt_q <= unloadDone ? doneCnt_q + 32'h1 : 32'h0;
   end
   hold_flag_pair_a: assert property (holdReceiver == !readyDischarge)
      else $error("hold flag wrong");
   ready_after_want_a: assert property ($rose(readyDischarge) |-> $past(wantUnload))
      else $error("ready without request");
   want_on_permit_a: assert property ($rose(wantUnload) |-> !$past(unloadPermit_n))
      else $error("request without permit");
   load_drop_run_a: assert property ($fell(loadRequest) |-> motorForward && $past(beltLoaded))
      else $error("load request dropped early");
   start_runs_belt_a: assert property ($rose(motorForward) && readyDischarge |-> $past(startCmd))
      else $error("motor without start");
   done_length_a: assert property ($fell(unloadDone) |-> doneCnt_q inside {[1999*TICK_CYC:2001*TICK_CYC+3]})
      else $error("done pulse length wrong");
   fault_held_a: assert property (faultCode != FLT_NONE && !faultAck |=> faultCode == $past(faultCode))
      else $error("fault changed without key");
   ack_clears_a: assert property (faultCode != FLT_NONE && faultAck |=> faultCode == FLT_NONE)
      else $error("fault kept after key");
   nogoods_cause_a: assert property ($changed(faultCode) && faultCode == FLT_NOGOODS |-> $past(motorForward))
      else $error("goods fault without run");
   transfer_cause_a: assert property ($changed(faultCode) && faultCode == FLT_TRANSFER |-> $past(abortCmd))
      else $error("transfer fault without abort");
   stuck_cause_a: assert property ($changed(faultCode) && faultCode == FLT_STUCK |->
      $past(beltLoaded) || $past(codeLatch))
      else $error("stuck fault with switches reset");
endmodule : mlh_loader_sva
bind mlh_loader mlh_loader_sva #(.TICK_CYC(TICK_CYC)) chk (.clk, .reset_n, .codeLatch, .beltLoaded, .unloadPermit_n,
   .startCmd, .abortCmd, .faultAck, .loadRequest, .motorForward, .wantUnload, .readyDischarge, .holdReceiver,
   .unloadDone, .faultCode);

// file: verif/mlh_ctrl_model.sv
// Line controller model: answers an unload request with prepare, then start.
// Assumes the loader's outputs are registered on the same clock.
`timescale 1ns/10ps
module mlh_ctrl_model
(
   input wire logic clk,
   input wire logic wantUnload,
   input wire logic readyDischarge,
   input wire logic [7:0] lag,
   output logic prepareCmd,
   output logic startCmd
);
   logic [7:0] waitCnt_q;
   // Idle commands are low from the start.
   initial
   begin
      prepareCmd = 1'b0;
      startCmd = 1'b0;
      waitCnt_q = 8'h00;
   end
   // Each reply waits lag cycles, so a prompt and a slow controller can both be played.
   always @(posedge clk)
   begin
      if (prepareCmd || startCmd || !(wantUnload || readyDischarge))
         waitCnt_q <= 8'h00;
      else
         waitCnt_q <= waitCnt_q + 8'h01;
      prepareCmd <= wantUnload && waitCnt_q >= lag;
      startCmd <= readyDischarge && waitCnt_q >= lag;
   end
endmodule : mlh_ctrl_model

// file: verif/testbench.sv
// Bench of the loader: the bench is the operator, a model is the line controller.
// Assumes package, register header, model and checker are compiled first.
`timescale 1ns/10ps
`include "mlh_regs.svh"
module testbench;
   import mlh_pkg::*;
   localparam int TC = 4;
   localparam int LR = 0, MF = 1, RD = 2, UD = 3, FT = 4, WU = 5;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [5:0] washCodeIn = 6'h00;
   logic codeLatch = 1'b0;
   logic beltLoaded = 1'b0;
   logic photoeyeBlocked = 1'b0;
   logic unloadPermit_n = 1'b1;
   logic abortCmd = 1'b0;
   logic faultAck = 1'b0;
   logic [7:0] lag = 8'h00;
   logic prepareCmd;
   logic startCmd;
   logic [31:0] regRdData;
   logic loadRequest;
   logic motorForward;
   logic wantUnload;
   logic readyDischarge;
   logic holdReceiver;
   logic unloadDone;
   logic [5:0] washCodeOut;
   logic washCodeValid;
   mlh_fault_e faultCode;
   logic irq;
   logic [5:0] mon;
   int numErrors = 0;
   int nChecks = 0;
   // A 125 MHz clock.
   always #4 clk = ~clk;
   // Flags gathered so that one bounded wait serves them all.
   assign mon = {wantUnload, faultCode != FLT_NONE, unloadDone, readyDischarge, motorForward, loadRequest};
   mlh_loader #(.TICK_CYC(TC)) dut (.clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .washCodeIn, .codeLatch, .beltLoaded, .photoeyeBlocked, .unloadPermit_n, .prepareCmd, .startCmd,
      .abortCmd, .faultAck, .loadRequest, .motorForward, .wantUnload, .readyDischarge, .holdReceiver,
      .unloadDone, .washCodeOut, .washCodeValid, .faultCode, .irq);
   mlh_ctrl_model ctrl (.clk, .wantUnload, .readyDischarge, .lag, .prepareCmd, .startCmd);
   task automatic endSim;
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : endSim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         numErrors++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // Bounded wait; running out counts as a mismatch and ends the run.
   task automatic waitBit(input int k, input logic v, input int lim);
      for (int i = 0; i < lim && mon[k] !== v; i++)
         cyc(1);
      if (mon[k] !== v)
      begin
         chk(mon[k], v);
         endSim();
      end
   endtask : waitBit
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask : rd
   // Loaded switch made before the code is latched must not end loading.
   task automatic loadBelt(input logic [5:0] code);
      @(posedge clk);
      washCodeIn <= code;
      beltLoaded <= 1'b1;
      @(posedge clk);
      codeLatch <= 1'b1;
      cyc(1);
      chk(loadRequest, 1'b1);
      cyc(1);
      chk({loadRequest, motorForward}, 2'b01);
      chk(washCodeOut, code);
      chk(washCodeValid, 1'b1);
   endtask : loadBelt
   // Key clears the fault; loading resumes only once both switches are reset.
   task automatic recover;
      @(posedge clk);
      faultAck <= 1'b1;
      @(posedge clk);
      faultAck <= 1'b0;
      #1 chk(faultCode, FLT_NONE);
      chk(loadRequest, 1'b0);
      @(posedge clk);
      beltLoaded <= 1'b0;
      codeLatch <= 1'b0;
      photoeyeBlocked <= 1'b0;
      waitBit(LR, 1'b1, 10);
   endtask : recover
   // Reset values, read-only status, unmapped address and a short belt timeout.
   task automatic sRegs;
      chk(loadRequest, 1'b1);
      rd(`MLH_OFF_TIMEOUT, 32'(`MLH_TIMEOUT_RST));
      rd(`MLH_OFF_CTRL, 32'h0);
      wr(`MLH_OFF_STATUS, 32'hFFFF);
      rd(`MLH_OFF_STATUS, 32'h0);
      rd(8'h14, 32'h0);
      wr(`MLH_OFF_TIMEOUT, 32'h3);
      rd(`MLH_OFF_TIMEOUT, 32'h3);
      wr(`MLH_OFF_IRQ_MASK, 32'hF);
      chk(motorForward, 1'b0);
      wr(`MLH_OFF_CTRL, 32'h1);
      waitBit(MF, 1'b1, 600 * TC);
      wr(`MLH_OFF_CTRL, 32'h0);
      waitBit(MF, 1'b0, 600 * TC);
   endtask : sRegs
   // Eye never blocks: goods fault, interrupt masked and cleared, fault held.
   task automatic sNoGoods;
      loadBelt(6'h2A);
      waitBit(FT, 1'b1, 100);
      chk(faultCode, FLT_NOGOODS);
      cyc(2);
      chk({motorForward, irq}, 2'b01);
      rd(`MLH_OFF_IRQ_STAT, 32'h1);
      wr(`MLH_OFF_IRQ_MASK, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      wr(`MLH_OFF_IRQ_MASK, 32'hF);
      wr(`MLH_OFF_IRQ_STAT, 32'h1);
      cyc(2);
      chk(irq, 1'b0);
      chk(faultCode, FLT_NOGOODS);
      recover();
   endtask : sNoGoods
   // Prompt controller; discharge aborted part way.
   task automatic sTransfer;
      loadBelt(6'h01);
      @(posedge clk);
      photoeyeBlocked <= 1'b1;
      cyc(2);
      chk({motorForward, wantUnload}, 2'b00);
      @(posedge clk);
      unloadPermit_n <= 1'b0;
      waitBit(WU, 1'b1, 5);
      waitBit(RD, 1'b1, 20);
      chk(holdReceiver, 1'b0);
      waitBit(MF, 1'b1, 20);
      @(posedge clk);
      abortCmd <= 1'b1;
      @(posedge clk);
      abortCmd <= 1'b0;
      #1 chk(faultCode, FLT_TRANSFER);
      recover();
   endtask : sTransfer
   // Slow controller, full discharge, switches left made afterwards.
   task automatic sFull;
      lag <= 8'd30;
      loadBelt(6'h3F);
      @(posedge clk);
      photoeyeBlocked <= 1'b1;
      waitBit(RD, 1'b1, 80);
      chk(motorForward, 1'b0);
      waitBit(MF, 1'b1, 80);
      @(posedge clk);
      photoeyeBlocked <= 1'b0;
      waitBit(UD, 1'b1, 100);
      chk(motorForward, 1'b0);
      waitBit(UD, 1'b0, 2002 * TC);
      waitBit(FT, 1'b1, 5002 * TC);
      chk(faultCode, FLT_STUCK);
      rd(`MLH_OFF_IRQ_STAT, 32'hE);
      recover();
   endtask : sFull
   // Reset held ten cycles, then the scenarios in turn.
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      cyc(4);
      sRegs();
      sNoGoods();
      sTransfer();
      sFull();
      endSim();
   end
endmodule : testbench
